// [common/dmi_pkg.sv]
// constants shared by the data memory block and its byte store
package dmi_pkg;

    // widths
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 7;
    localparam int EFF_W   = 8;
    localparam int MEM_AW  = 6;
    localparam int MEM_DEPTH = 64;

    // special function area, direct offsets in bank 0
    localparam logic [ADDR_W-1:0] OFS_WIN0  = 7'h00;
    localparam logic [ADDR_W-1:0] OFS_PTR0  = 7'h01;
    localparam logic [ADDR_W-1:0] OFS_WIN1  = 7'h02;
    localparam logic [ADDR_W-1:0] OFS_PTR1  = 7'h03;
    localparam logic [ADDR_W-1:0] OFS_TRACE = 7'h04;
    localparam logic [ADDR_W-1:0] OFS_ACC   = 7'h05;
    localparam logic [ADDR_W-1:0] OFS_PCL   = 7'h06;

    // field positions of an effective address
    localparam int BANK_BIT = 7;
    localparam int GP_MSB   = 6;
    localparam int GP_LSB   = 5;
    localparam int ROW_MSB  = 4;

    // general purpose area occupies 60H..7FH of each bank
    localparam logic [1:0] GP_SEL = 2'h3;

    // reset and fixed values
    localparam logic [DATA_W-1:0] RST_BYTE  = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] PC_STEP   = 8'h01;
    localparam logic [EFF_W-1:0]  RST_EFF   = 8'h00;

    // timing: cycles inserted after a program counter low write
    localparam int DUMMY_CYCLES = 1;

endpackage

// [rtl/dmi_byte_ram.sv]
// general purpose byte store with registered read port
`timescale 1ns/100ps

module dmi_byte_ram
    import dmi_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                we,
    input  wire logic [MEM_AW-1:0]   waddr,
    input  wire logic [DATA_W-1:0]   wdata,
    input  wire logic                re,
    input  wire logic [MEM_AW-1:0]   raddr,
    output logic      [DATA_W-1:0]   rdata
);
    import dmi_pkg::*;

    // array carries no reset: contents are undefined at power-up
    logic [DATA_W-1:0] mem_r [MEM_DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= RST_BYTE;
        end else if (re) begin
            rdata <= mem_r[raddr];
        end
    end

endmodule

// [rtl/dmi_data_mem.sv]
// byte-wide data memory with indirect windows and program counter low
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - every location holds one byte, accessed whole
// - address space starts at zero, special registers below general area
// - general purpose locations are readable and writable
// - some special locations ignore program writes
// - window accesses go to the address held in the paired pointer
// - first pointer reaches bank 0 only, second reaches any bank
// - indirect read of a window location returns zero
// - write to a window location with no redirect target does nothing
// - pointers are real storage, written like any register
// - direct addresses select bank 0 only
// - each pointer is eight bits; the second uses all eight as the indirect address, the first only the low seven
// - arithmetic results load straight into the accumulator
// - no register-to-register move; writes take core write data only
// - program counter low byte is mapped into special area
// - writing program counter low jumps within the current page
// - a program counter low write inserts one dummy cycle
module dmi_data_mem
    import dmi_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic [ADDR_W-1:0]     addr,
    input  wire logic [DATA_W-1:0]     wr_data,
    input  wire logic                  wr_en,
    input  wire logic                  rd_en,
    output logic      [DATA_W-1:0]     rd_data,
    input  wire logic [DATA_W-1:0]     alu_result,
    input  wire logic                  acc_load,
    output logic      [DATA_W-1:0]     acc_value,
    input  wire logic                  pc_advance,
    output logic      [DATA_W-1:0]     pc_low,
    output logic                       pc_jump,
    output logic                       dummy_cycle
);
    import dmi_pkg::*;

    logic [DATA_W-1:0] ptr0_r;
    logic [DATA_W-1:0] ptr1_r;
    logic [DATA_W-1:0] acc_r;
    logic [DATA_W-1:0] pcl_r;
    logic [EFF_W-1:0]  trace_r;
    logic              jump_r;
    logic              dummy_r;
    logic              sel_mem_r;
    logic [DATA_W-1:0] sfr_q_r;

    logic              ind;
    logic              ind0;
    logic [EFF_W-1:0]  eff;
    logic              eff_bank0;
    logic              gp_hit;
    logic              win_hit;
    logic              sfr_ptr0;
    logic              sfr_ptr1;
    logic              sfr_acc;
    logic              sfr_pcl;
    logic              sfr_trace;
    logic              any_hit;
    logic              mem_we;
    logic              mem_re;
    logic [MEM_AW-1:0] mem_addr;
    logic [DATA_W-1:0] mem_q;
    logic [DATA_W-1:0] sfr_rd;
    logic              pcl_wr;

    ////////////////////////////////////////////////////////////////////////////
    // address resolution

    always_comb begin
        ind  = 1'b0;
        ind0 = 1'b0;
        eff  = {1'b0, addr};
        if (addr == OFS_WIN0) begin
            ind  = 1'b1;
            ind0 = 1'b1;
            eff  = {1'b0, ptr0_r[ADDR_W-1:0]};
        end else if (addr == OFS_WIN1) begin
            ind = 1'b1;
            eff = ptr1_r;
        end
    end

    // special registers sit low in bank 0
    assign eff_bank0 = !eff[BANK_BIT];
    assign gp_hit    = (eff[GP_MSB:GP_LSB] == GP_SEL);
    assign win_hit   = eff_bank0 && ((eff[ADDR_W-1:0] == OFS_WIN0)
                                  || (eff[ADDR_W-1:0] == OFS_WIN1));
    assign sfr_ptr0  = eff_bank0 && (eff[ADDR_W-1:0] == OFS_PTR0);
    assign sfr_ptr1  = eff_bank0 && (eff[ADDR_W-1:0] == OFS_PTR1);
    assign sfr_acc   = eff_bank0 && (eff[ADDR_W-1:0] == OFS_ACC);
    assign sfr_pcl   = eff_bank0 && (eff[ADDR_W-1:0] == OFS_PCL);
    assign sfr_trace = eff_bank0 && (eff[ADDR_W-1:0] == OFS_TRACE);
    assign any_hit   = gp_hit || sfr_ptr0 || sfr_ptr1 || sfr_acc
                    || sfr_pcl || sfr_trace;

    ////////////////////////////////////////////////////////////////////////////
    // general purpose store

    // only core write data reaches storage
    assign mem_we   = wr_en && gp_hit;
    assign mem_re   = rd_en && gp_hit;
    assign mem_addr = {eff[BANK_BIT], eff[ROW_MSB:0]};

    dmi_byte_ram u_ram (
        .clk   (clk),
        .rst_b (rst_b),
        .we    (mem_we),
        .waddr (mem_addr),
        .wdata (wr_data),
        .re    (mem_re),
        .raddr (mem_addr),
        .rdata (mem_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pointers

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr0_r <= RST_BYTE;
        end else if (wr_en && sfr_ptr0) begin
            ptr0_r <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr1_r <= RST_BYTE;
        end else if (wr_en && sfr_ptr1) begin
            ptr1_r <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // accumulator

    // arithmetic result into accumulator
    // an alu load beats a bus write in the same cycle: it is the newer result
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_r <= RST_BYTE;
        end else if (acc_load) begin
            acc_r <= alu_result;
        end else if (wr_en && sfr_acc) begin
            acc_r <= wr_data;
        end
    end

    assign acc_value = acc_r;

    ////////////////////////////////////////////////////////////////////////////
    // protected trace of the last indirect target

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trace_r <= RST_EFF;
        end else if ((wr_en || rd_en) && ind) begin
            trace_r <= eff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // program counter low byte

    assign pcl_wr = wr_en && sfr_pcl;

    // in-page jump, low byte only
    // the advance is held during the dummy cycle so the target is not skipped
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pcl_r <= RST_BYTE;
        end else if (pcl_wr) begin
            pcl_r <= wr_data;
        end else if (pc_advance && !dummy_r) begin
            pcl_r <= pcl_r + PC_STEP;
        end
    end

    // one dummy cycle after a jump
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            jump_r  <= 1'b0;
            dummy_r <= 1'b0;
        end else begin
            jump_r  <= pcl_wr;
            dummy_r <= pcl_wr;
        end
    end

    assign pc_low      = pcl_r;
    assign pc_jump     = jump_r;
    assign dummy_cycle = dummy_r;

    ////////////////////////////////////////////////////////////////////////////
    // read path

    always_comb begin
        sfr_rd = ZERO_BYTE;
        if (sfr_ptr0) begin
            sfr_rd = ptr0_r;
        end else if (sfr_ptr1) begin
            sfr_rd = ptr1_r;
        end else if (sfr_acc) begin
            sfr_rd = acc_r;
        end else if (sfr_pcl) begin
            sfr_rd = pcl_r;
        end else if (sfr_trace) begin
            sfr_rd = trace_r;
        end
    end

    // whole byte returned a cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_mem_r <= 1'b0;
            sfr_q_r   <= RST_BYTE;
        end else if (rd_en) begin
            sel_mem_r <= gp_hit;
            sfr_q_r   <= sfr_rd;
        end
    end

    // select only: both sources are registers, so no logic sits after them
    assign rd_data = sel_mem_r ? mem_q : sfr_q_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [ADDR_W-1:0] chk_addr_r;
    logic [DATA_W-1:0] chk_data_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chk_addr_r <= OFS_WIN0;
            chk_data_r <= RST_BYTE;
        end else begin
            chk_addr_r <= addr;
            chk_data_r <= wr_data;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_gp_write;
        wr_en && !ind && gp_hit;
    endsequence

    sequence s_same_read;
        rd_en && !wr_en && !ind && (addr == chk_addr_r);
    endsequence

    a_gp_readback: assert property (
        s_gp_write ##1 s_same_read |=> rd_data == $past(chk_data_r))
        else $error("general purpose byte did not read back");

    a_protect_trace: assert property (
        wr_en && !rd_en && !ind |=> trace_r == $past(trace_r))
        else $error("protected location changed on a direct write");

    a_ptr0_bank_zero: assert property (
        (wr_en || rd_en) && ind0 |-> !eff[BANK_BIT])
        else $error("first pointer reached beyond bank 0");

    a_win_read_zero: assert property (
        rd_en && ind && win_hit |=> rd_data == ZERO_BYTE)
        else $error("indirect window read was not zero");

    a_win_write_none: assert property (
        wr_en && win_hit |-> !mem_we && !pcl_wr)
        else $error("window write reached storage");

    a_ptr_storage: assert property (
        wr_en && !ind && addr == OFS_PTR1 |=> ptr1_r == $past(wr_data))
        else $error("pointer did not take written byte");

    a_acc_load: assert property (
        acc_load |=> acc_value == $past(alu_result))
        else $error("accumulator missed the alu result");

    sequence s_pcl_write;
        pcl_wr;
    endsequence

    sequence s_jump_seen;
        pc_jump && dummy_cycle && pc_low == chk_data_r;
    endsequence

    a_pcl_jump: assert property (
        s_pcl_write |=> s_jump_seen)
        else $error("program counter low write did not jump");

    a_dummy_once: assert property (
        dummy_cycle && !pcl_wr |-> ##1 (!dummy_cycle && $stable(pc_low)))
        else $error("dummy cycle too long or counter moved");

    a_unused_zero: assert property (
        rd_en && !any_hit |=> rd_data == ZERO_BYTE)
        else $error("unused address did not read zero");

endmodule

// [testbench/dmi_core_model.sv]
// core datapath model: steps the program counter and loads the accumulator
`timescale 1ns/100ps

module dmi_core_model
    import dmi_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              step_en,
    output logic                   pc_advance,
    output logic                   acc_load,
    output logic      [DATA_W-1:0] alu_result
);
    import dmi_pkg::*;

    initial begin
        acc_load = 1'b0;
        alu_result = ZERO_BYTE;
    end

    // core keeps stepping
    // no gating here: the block itself must ignore the step in a dummy cycle
    assign pc_advance = step_en;

    task automatic load(input logic [DATA_W-1:0] v);
        @(posedge clk);
        alu_result <= v;
        acc_load <= 1'b1;
        @(posedge clk);
        acc_load <= 1'b0;
        // result bus released: show a changed value, not a stale one
        alu_result <= ~v;
    endtask
endmodule

// [testbench/tb_dmi_data_mem.sv]
// self-checking bench for the data memory block
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module tb_dmi_data_mem;
    import dmi_pkg::*;

    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    logic [ADDR_W-1:0] addr = 7'h00;
    logic [DATA_W-1:0] wr_data = 8'h00;
    logic              wr_en = 1'b0;
    logic              rd_en = 1'b0;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] alu_result;
    logic              acc_load;
    logic [DATA_W-1:0] acc_value;
    logic              pc_advance;
    logic [DATA_W-1:0] pc_low;
    logic              pc_jump;
    logic              dummy_cycle;
    logic              step_en = 1'b0;
    int                n_errors = 0;
    int                compares = 0;

    always #50 clk = ~clk;

    dmi_data_mem dmi_data_mem_inst (
        .clk         (clk),
        .rst_b       (rst_b),
        .addr        (addr),
        .wr_data     (wr_data),
        .wr_en       (wr_en),
        .rd_en       (rd_en),
        .rd_data     (rd_data),
        .alu_result  (alu_result),
        .acc_load    (acc_load),
        .acc_value   (acc_value),
        .pc_advance  (pc_advance),
        .pc_low      (pc_low),
        .pc_jump     (pc_jump),
        .dummy_cycle (dummy_cycle)
    );

    dmi_core_model dmi_core_model_inst (
        .clk         (clk),
        .step_en     (step_en),
        .pc_advance  (pc_advance),
        .acc_load    (acc_load),
        .alu_result  (alu_result)
    );

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // data stand from the cycle after the strobe until the next strobe: sample mid-cycle
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        `CHK(rd_data, e)
    endtask

    // write then read the same byte with no idle cycle between the strobes
    task automatic wr_rd(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        `CHK(rd_data, d)
    endtask

    task automatic final_report;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #(4000 * 100);
        n_errors++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        `CHK(pc_low, RST_BYTE)
        `CHK(acc_value, RST_BYTE)
        `CHK(pc_jump, 1'b0)
        rd(OFS_PTR0, RST_BYTE);
        $display("test reset done");

        wr(7'h60, 8'hA5);
        wr(7'h7F, 8'h5A);
        rd(7'h60, 8'hA5);
        rd(7'h7F, 8'h5A);
        wr(7'h07, 8'hFF);
        wr(7'h5F, 8'hFF);
        rd(7'h07, ZERO_BYTE);
        rd(7'h5F, ZERO_BYTE);
        wr_rd(7'h70, 8'hC3);
        $display("test direct done");

        wr(OFS_PTR0, 8'h61);
        wr(OFS_WIN0, 8'h3C);
        rd(7'h61, 8'h3C);
        wr(OFS_PTR0, 8'hE1);
        wr(OFS_WIN0, 8'h77);
        rd(7'h61, 8'h77);
        wr(7'h62, 8'h11);
        wr(OFS_PTR1, 8'hE2);
        wr(OFS_WIN1, 8'h55);
        rd(OFS_WIN1, 8'h55);
        rd(7'h62, 8'h11);
        wr(OFS_TRACE, 8'hFF);
        rd(OFS_TRACE, 8'hE2);
        $display("test indirect done");

        wr(OFS_PTR0, 8'h00);
        wr(OFS_WIN0, 8'hAB);
        rd(OFS_WIN0, ZERO_BYTE);
        wr(OFS_PTR1, 8'h02);
        wr(OFS_WIN1, 8'hCD);
        rd(OFS_PTR1, 8'h02);
        rd(OFS_WIN1, ZERO_BYTE);
        rd(7'h60, 8'hA5);
        rd(7'h62, 8'h11);
        $display("test window done");

        dmi_core_model_inst.load(8'h3C);
        @(negedge clk);
        `CHK(acc_value, 8'h3C)
        rd(OFS_ACC, 8'h3C);
        wr(OFS_ACC, 8'h9E);
        rd(OFS_ACC, 8'h9E);
        // alu load and bus write at one edge: the alu result must win
        fork
            dmi_core_model_inst.load(8'h12);
            wr(OFS_ACC, 8'h34);
        join
        @(negedge clk);
        `CHK(acc_value, 8'h12)
        $display("test accumulator done");

        step_en <= 1'b1;
        wr(OFS_PCL, 8'h40);
        @(negedge clk);
        `CHK(pc_low, 8'h40)
        `CHK(pc_jump, 1'b1)
        `CHK(dummy_cycle, 1'b1)
        @(negedge clk);
        `CHK(pc_low, 8'h40)
        `CHK(dummy_cycle, 1'b0)
        @(negedge clk);
        `CHK(pc_low, 8'h41)
        step_en <= 1'b0;
        $display("test program counter done");
        final_report();
    end
endmodule
